// file: common/lpm_params.svh
// offsets, field positions, reset values and sizes of the low power mode control block
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

`define LPM_ADDR_W        8
`define LPM_DATA_W        32

`define LPM_OFF_DIV       8'h00
`define LPM_OFF_MSTP      8'h04
`define LPM_OFF_SBY       8'h08
`define LPM_OFF_STAT      8'h0C

`define LPM_NUM_CLK       4
`define LPM_DIV_FW        3
`define LPM_DIV_W         12
`define LPM_DIV_RST       12'h000

`define LPM_MSTP_RST      32'hFFFF_FFFF

`define LPM_SBY_SEL_LSB   0
`define LPM_SBY_PM_BIT    8
`define LPM_SBY_SEL_RST   2'h0
`define LPM_SBY_PM_RST    1'h0

`define LPM_STAT_ST_LSB   0
`define LPM_STAT_PM_BIT   8
`define LPM_STAT_HALT_BIT 16

`define LPM_CK_CORE       0
`define LPM_CK_PBUS       1
`define LPM_CK_CONV       2
`define LPM_CK_FLASH      3

`define LPM_CNT_W         7
`define LPM_PRIMARY_RAM_REGION_LAST     32'h0000_2FFF

`endif

// file: common/lpm_pkg.sv
// types shared by the low power mode control block
`default_nettype none
package lpm_pkg;

    typedef enum logic [1:0] {
        LPM_RUN,
        LPM_SLEEP,
        LPM_DSLEEP,
        LPM_SSTBY
    } lpm_state_e;

    typedef enum logic [1:0] {
        LPM_SEL_SLEEP,
        LPM_SEL_DEEP,
        LPM_SEL_SSTBY,
        LPM_SEL_RSVD
    } lpm_lpsel_e;

    typedef enum logic {
        LPM_PM_HIGH,
        LPM_PM_MIDDLE
    } lpm_pmode_e;

    // clock enables, one per divided clock
    typedef struct packed {
        logic flash_interface_clock;
        logic converter_clock;
        logic peripheral_bus_clock;
        logic core_clock;
    } lpm_clk_s;

    // oscillator stop requests
    typedef struct packed {
        logic slow_internal_oscillator;
        logic fast_internal_oscillator;
        logic main_oscillator;
    } lpm_osc_s;

endpackage : lpm_pkg
`default_nettype wire

// file: rtl/lpm_clkdiv.sv
// power-of-two clock enable divider
`timescale 1ns/1ps
`default_nettype none
`include "lpm_params.svh"

module lpm_clkdiv (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // ratio select, divide by two to the ratio
    input  wire logic [`LPM_DIV_FW-1:0]  ratio,
    // one-cycle enable pulse
    output logic                         tick_q
);
    logic [`LPM_CNT_W-1:0] cnt_q;
    logic [`LPM_CNT_W-1:0] cnt_d;
    wire  [`LPM_CNT_W-1:0] lim_w;
    wire                   wrap_w;

    assign lim_w  = `LPM_CNT_W'((1 << ratio) - 1);
    // compare with >= so a smaller ratio written mid-count wraps at once
    assign wrap_w = (cnt_q >= lim_w);
    assign cnt_d  = wrap_w ? '0 : cnt_q + `LPM_CNT_W'(1);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= wrap_w;
        end
    end
endmodule : lpm_clkdiv

`default_nettype wire

// file: rtl/lpm_ctrl.sv
// low power mode control: clock dividers, module stop, sleep and standby sequencing
//
// Operation
// - each of the four clocks has its own software-set division ratio.
// - one stop bit per peripheral halts that peripheral alone.
// - low power states halt core, peripherals or oscillators per state.
// - three selectable low power states: sleep, deep sleep, software standby.
// - selected power control mode applies in run, sleep and deep sleep.
// - only an interrupt (or reset) ends sleep; core resumes with interrupt.
// - in sleep primary ram region stays accessible; transfer controller may run.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_params.svh"

module lpm_ctrl #(
    parameter int NUM_MOD = 16
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // register port
    input  wire logic [`LPM_ADDR_W-1:0]   addr,
    input  wire logic [`LPM_DATA_W-1:0]   wdata,
    input  wire logic                     we,
    input  wire logic                     re,
    output logic      [`LPM_DATA_W-1:0]   rdata_q,
    // core side
    input  wire logic                     wait_exec,
    input  wire logic                     irq_pending,
    output logic                          core_halt_q,
    output logic                          wake_resume_q,
    // clocks and oscillators
    output lpm_pkg::lpm_clk_s             clk_en_q,
    output lpm_pkg::lpm_osc_s             osc_stop_q,
    output lpm_pkg::lpm_pmode_e           power_mode_q,
    // peripherals
    output logic      [NUM_MOD-1:0]       periph_run_q,
    output logic                          xfer_run_q,
    // primary ram region
    input  wire logic                     ram_req,
    input  wire logic [31:0]              ram_addr,
    output logic                          ram_ok_q,
    output logic                          ram_grant_q
);
    import lpm_pkg::*;

    // register state
    logic [`LPM_DIV_W-1:0]   div_q;
    logic [NUM_MOD-1:0]      mstp_q;
    lpm_lpsel_e              lpsel_q;
    lpm_pmode_e              pmsel_q;
    lpm_state_e              state_q;
    lpm_state_e              state_d;

    // decode and select
    wire                     sel_div_w;
    wire                     sel_mstp_w;
    wire                     sel_sby_w;
    wire                     sel_stat_w;
    wire [`LPM_DATA_W-1:0]   rd_div_w;
    wire [`LPM_DATA_W-1:0]   rd_mstp_w;
    wire [`LPM_DATA_W-1:0]   rd_sby_w;
    wire [`LPM_DATA_W-1:0]   rd_stat_w;
    wire [`LPM_DATA_W-1:0]   rd_mux_w;

    // sequencing
    wire                     wake_d;
    wire                     in_run_d;
    wire                     in_sleep_d;
    wire                     in_sstby_d;
    wire [`LPM_NUM_CLK-1:0]  dom_run_d;
    wire [`LPM_NUM_CLK-1:0]  tick_w;
    wire [`LPM_NUM_CLK-1:0]  clk_en_d;
    wire [NUM_MOD-1:0]       periph_run_d;
    wire                     ram_ok_d;
    wire                     ram_hit_w;

    assign sel_div_w  = (addr == `LPM_OFF_DIV);
    assign sel_mstp_w = (addr == `LPM_OFF_MSTP);
    assign sel_sby_w  = (addr == `LPM_OFF_SBY);
    assign sel_stat_w = (addr == `LPM_OFF_STAT);

    assign rd_div_w   = `LPM_DATA_W'(div_q);
    assign rd_mstp_w  = `LPM_DATA_W'(mstp_q);
    assign rd_sby_w   = (`LPM_DATA_W'(lpsel_q) << `LPM_SBY_SEL_LSB)
                      | (`LPM_DATA_W'(pmsel_q) << `LPM_SBY_PM_BIT);
    assign rd_stat_w  = (`LPM_DATA_W'(state_q) << `LPM_STAT_ST_LSB)
                      | (`LPM_DATA_W'(power_mode_q) << `LPM_STAT_PM_BIT)
                      | (`LPM_DATA_W'(core_halt_q) << `LPM_STAT_HALT_BIT);

    // unmapped addresses read as zero
    assign rd_mux_w   = sel_div_w  ? rd_div_w  :
                        sel_mstp_w ? rd_mstp_w :
                        sel_sby_w  ? rd_sby_w  :
                        sel_stat_w ? rd_stat_w : '0;

    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q   <= `LPM_DIV_RST;
            mstp_q  <= NUM_MOD'(`LPM_MSTP_RST);
            lpsel_q <= lpm_lpsel_e'(`LPM_SBY_SEL_RST);
            pmsel_q <= lpm_pmode_e'(`LPM_SBY_PM_RST);
        end else if (we) begin
            if (sel_div_w) begin
                div_q <= wdata[`LPM_DIV_W-1:0];
            end
            if (sel_mstp_w) begin
                mstp_q <= wdata[NUM_MOD-1:0];
            end
            if (sel_sby_w) begin
                lpsel_q <= lpm_lpsel_e'(wdata[`LPM_SBY_SEL_LSB +: 2]);
                pmsel_q <= lpm_pmode_e'(wdata[`LPM_SBY_PM_BIT]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= re ? rd_mux_w : '0;
        end
    end

    // state sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            LPM_RUN: begin
                // the select is taken at the wait instruction, not at the write
                if (wait_exec) begin
                    case (lpsel_q)
                        LPM_SEL_SLEEP: state_d = LPM_SLEEP;
                        LPM_SEL_DEEP:  state_d = LPM_DSLEEP;
                        LPM_SEL_SSTBY: state_d = LPM_SSTBY;
                        default:       state_d = LPM_SLEEP;
                    endcase
                end
            end
            LPM_SLEEP, LPM_DSLEEP, LPM_SSTBY: begin
                if (irq_pending) begin
                    state_d = LPM_RUN;
                end
            end
            default: state_d = LPM_RUN;
        endcase
    end

    assign wake_d     = (state_q != LPM_RUN) && irq_pending;
    assign in_run_d   = (state_d == LPM_RUN);
    assign in_sleep_d = (state_d == LPM_SLEEP);
    assign in_sstby_d = (state_d == LPM_SSTBY);

    // which divided clocks run in each state
    assign dom_run_d[`LPM_CK_CORE]  = in_run_d;
    assign dom_run_d[`LPM_CK_PBUS]  = !in_sstby_d;
    assign dom_run_d[`LPM_CK_CONV]  = !in_sstby_d;
    assign dom_run_d[`LPM_CK_FLASH] = in_run_d || in_sleep_d;

    genvar gi;
    generate
        for (gi = 0; gi < `LPM_NUM_CLK; gi++) begin : g_div
            lpm_clkdiv u_div (
                .clk    (clk),
                .rst    (rst),
                .ratio  (div_q[gi*`LPM_DIV_FW +: `LPM_DIV_FW]),
                .tick_q (tick_w[gi])
            );
            assign clk_en_d[gi] = tick_w[gi] && dom_run_d[gi];
        end
        for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
            // a stopped module stays stopped whatever the state
            assign periph_run_d[gi] = !mstp_q[gi] && !in_sstby_d;
        end
    endgenerate

    // ram stays usable in sleep only; deep sleep keeps contents, no access
    assign ram_ok_d  = in_run_d || in_sleep_d;
    assign ram_hit_w = ram_req && (ram_addr <= `LPM_PRIMARY_RAM_REGION_LAST);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q       <= LPM_RUN;
            core_halt_q   <= 1'b0;
            wake_resume_q <= 1'b0;
            clk_en_q      <= '0;
            osc_stop_q    <= '0;
            periph_run_q  <= '0;
            xfer_run_q    <= 1'b1;
            ram_ok_q      <= 1'b1;
            ram_grant_q   <= 1'b0;
        end else begin
            state_q       <= state_d;
            core_halt_q   <= !in_run_d;
            wake_resume_q <= wake_d;
            clk_en_q      <= lpm_clk_s'(clk_en_d);
            osc_stop_q    <= in_sstby_d ? '1 : '0;
            periph_run_q  <= periph_run_d;
            xfer_run_q    <= ram_ok_d;
            ram_ok_q      <= ram_ok_d;
            ram_grant_q   <= ram_hit_w && ram_ok_d;
        end
    end

    // mode is frozen in standby, where the regulator setting is not used
    always_ff @(posedge clk) begin
        if (rst) begin
            power_mode_q <= LPM_PM_HIGH;
        end else if (!in_sstby_d) begin
            power_mode_q <= pmsel_q;
        end
    end

    // checks
    property p_div_spacing;
        @(posedge clk) disable iff (rst)
        // ratio 0 ticks every cycle, so only a nonzero ratio is watched
        (tick_w[`LPM_CK_PBUS] && (div_q[`LPM_CK_PBUS*`LPM_DIV_FW +: `LPM_DIV_FW] != '0)
            && $stable(div_q))
            |=> !tick_w[`LPM_CK_PBUS];
    endproperty
    a_div_spacing: assert property (p_div_spacing)
        else $error("bus clock divider ticked twice in a row");

    property p_mstp_stop;
        @(posedge clk) disable iff (rst)
        mstp_q[0] |=> !periph_run_q[0];
    endproperty
    a_mstp_stop: assert property (p_mstp_stop)
        else $error("stopped peripheral still running");

    property p_sstby_osc;
        @(posedge clk) disable iff (rst)
        (state_q == LPM_SSTBY) |-> (osc_stop_q == '1) && core_halt_q && !clk_en_q.core_clock;
    endproperty
    a_sstby_osc: assert property (p_sstby_osc)
        else $error("standby without oscillators and core stopped");

    property p_enter_deep;
        @(posedge clk) disable iff (rst)
        (state_q == LPM_RUN && wait_exec && lpsel_q == LPM_SEL_DEEP)
            |=> (state_q == LPM_DSLEEP) && core_halt_q && !ram_ok_q;
    endproperty
    a_enter_deep: assert property (p_enter_deep)
        else $error("wait with deep sleep selected did not enter deep sleep");

    property p_pmode_apply;
        @(posedge clk) disable iff (rst)
        (state_d != LPM_SSTBY) ##1 (state_d != LPM_SSTBY) |-> (power_mode_q == $past(pmsel_q));
    endproperty
    a_pmode_apply: assert property (p_pmode_apply)
        else $error("power control mode not applied");

    property p_sleep_hold;
        @(posedge clk) disable iff (rst)
        (state_q == LPM_SLEEP && !irq_pending) |=> (state_q == LPM_SLEEP) && !wake_resume_q;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("sleep left without an interrupt");

    property p_sleep_wake;
        @(posedge clk) disable iff (rst)
        (state_q == LPM_SLEEP && irq_pending)
            |=> (state_q == LPM_RUN) && wake_resume_q && !core_halt_q;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("interrupt did not resume the core");

    property p_sleep_ram;
        @(posedge clk) disable iff (rst)
        (state_q == LPM_SLEEP) |-> ram_ok_q && xfer_run_q;
    endproperty
    a_sleep_ram: assert property (p_sleep_ram)
        else $error("ram or transfer controller blocked in sleep");

    property p_ram_range;
        @(posedge clk) disable iff (rst)
        (ram_req && (ram_addr > `LPM_PRIMARY_RAM_REGION_LAST)) |=> !ram_grant_q;
    endproperty
    a_ram_range: assert property (p_ram_range)
        else $error("access outside primary ram region granted");

    property p_deep_wake;
        @(posedge clk) disable iff (rst)
        ((state_q == LPM_DSLEEP || state_q == LPM_SSTBY) && irq_pending)
            |=> (state_q == LPM_RUN) && wake_resume_q && !core_halt_q;
    endproperty
    a_deep_wake: assert property (p_deep_wake)
        else $error("interrupt did not end deep sleep or standby");

    property p_run_hold;
        @(posedge clk) disable iff (rst)
        (state_q == LPM_RUN && !wait_exec) |=> (state_q == LPM_RUN) && !core_halt_q;
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("low power state entered without the wait instruction");

    // regulator setting is not used in standby, so it must not move there
    property p_sstby_mode;
        @(posedge clk) disable iff (rst)
        (state_q == LPM_SSTBY && in_sstby_d) |=> $stable(power_mode_q);
    endproperty
    a_sstby_mode: assert property (p_sstby_mode)
        else $error("power control mode changed in standby");

endmodule : lpm_ctrl

`default_nettype wire

// file: tb/lpm_ctrl_tb_top.sv
// self-checking bench for the low power mode control block
`timescale 1ns/1ps
`default_nettype none
`include "lpm_params.svh"

module lpm_ctrl_tb_top;
    import lpm_pkg::*;

    logic                    clk;
    logic                    rst;
    logic [`LPM_ADDR_W-1:0]  addr;
    logic [`LPM_DATA_W-1:0]  wdata;
    logic                    we;
    logic                    re;
    logic [`LPM_DATA_W-1:0]  rdata_q;
    logic                    wait_exec;
    logic                    irq_pending;
    logic                    core_halt_q;
    logic                    wake_resume_q;
    lpm_clk_s                clk_en_q;
    lpm_osc_s                osc_stop_q;
    lpm_pmode_e              power_mode_q;
    logic [15:0]             periph_run_q;
    logic                    xfer_run_q;
    logic                    ram_req;
    logic [31:0]             ram_addr;
    logic                    ram_ok_q;
    logic                    ram_grant_q;
    int                      bad_count;
    int                      n_tests;

    lpm_ctrl #(.NUM_MOD(16)) dut_u (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata_q(rdata_q), .wait_exec(wait_exec), .irq_pending(irq_pending),
        .core_halt_q(core_halt_q), .wake_resume_q(wake_resume_q),
        .clk_en_q(clk_en_q), .osc_stop_q(osc_stop_q), .power_mode_q(power_mode_q),
        .periph_run_q(periph_run_q), .xfer_run_q(xfer_run_q),
        .ram_req(ram_req), .ram_addr(ram_addr), .ram_ok_q(ram_ok_q),
        .ram_grant_q(ram_grant_q)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        we    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        we    <= 1'b0;
    endtask : reg_wr

    // data stand only in the cycle after the strobe, so sample right there
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        re   <= 1'b1;
        addr <= a;
        @(posedge clk);
        re   <= 1'b0;
        #1 d = rdata_q;
    endtask : reg_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        reg_rd(a, d);
        chk(d, exp);
    endtask : rd_chk

    task automatic pulse(input bit is_wait);
        @(posedge clk);
        if (is_wait) wait_exec <= 1'b1;
        else irq_pending <= 1'b1;
        @(posedge clk);
        wait_exec   <= 1'b0;
        irq_pending <= 1'b0;
        #1;
    endtask : pulse

    // counts enable pulses of each clock over n consecutive cycles
    task automatic count_en(input int n, output int c [4]);
        for (int k = 0; k < 4; k++) c[k] = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            for (int k = 0; k < 4; k++) c[k] += clk_en_q[k];
        end
    endtask : count_en

    task automatic ram_chk(input logic [31:0] a, input logic exp);
        @(posedge clk);
        ram_req  <= 1'b1;
        ram_addr <= a;
        @(posedge clk);
        ram_req  <= 1'b0;
        #1 chk(ram_grant_q, exp);
    endtask : ram_chk

    initial begin
        #200_000;
        bad_count++;
        summarize();
    end

    initial begin
        int          c [4];
        logic [3:0]  on;
        logic [1:0]  st;
        logic [31:0] d;
        rst = 1'b1; addr = '0; wdata = '0; we = 1'b0; re = 1'b0;
        wait_exec = 1'b0; irq_pending = 1'b0; ram_req = 1'b0; ram_addr = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({core_halt_q, xfer_run_q, ram_ok_q, osc_stop_q}, 32'h0000_0018);
        rd_chk(`LPM_OFF_DIV, 32'h0000_0000);
        rd_chk(`LPM_OFF_MSTP, 32'h0000_FFFF);
        rd_chk(`LPM_OFF_SBY, 32'h0000_0000);
        rd_chk(`LPM_OFF_STAT, 32'h0000_0000);
        rd_chk(8'h10, 32'h0000_0000);
        @(posedge clk);
        #1 chk(rdata_q, 32'h0000_0000);
        // ratios 0..3: core, bus, converter, flash; a window of 64 counts exactly
        reg_wr(`LPM_OFF_DIV, 32'h0000_0688);
        rd_chk(`LPM_OFF_DIV, 32'h0000_0688);
        count_en(64, c);
        for (int k = 0; k < 4; k++) chk(c[k], 64 >> k);
        reg_wr(`LPM_OFF_STAT, 32'hFFFF_FFFF);
        reg_wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(`LPM_OFF_STAT, 32'h0000_0000);
        // only peripherals 0 and 2 left running
        reg_wr(`LPM_OFF_MSTP, 32'hFFFF_FFFA);
        @(posedge clk);
        #1 chk(periph_run_q, 32'h0000_0005);
        pulse(1'b0);
        chk({wake_resume_q, core_halt_q}, 32'h0000_0000);
        for (int sel = 0; sel < 4; sel++) begin
            st = (sel == 3) ? 2'd1 : 2'(sel + 1);
            reg_wr(`LPM_OFF_SBY, 32'(sel) | (32'(sel & 1) << 8));
            pulse(1'b1);
            @(posedge clk);
            #1;
            chk(core_halt_q, 32'h1);
            chk(power_mode_q, 32'(sel & 1));
            chk(osc_stop_q, (st == 2'd3) ? 32'h7 : 32'h0);
            chk({xfer_run_q, ram_ok_q}, (st == 2'd1) ? 32'h3 : 32'h0);
            chk(periph_run_q, (st == 2'd3) ? 32'h0 : 32'h5);
            rd_chk(`LPM_OFF_STAT, 32'h0001_0000 | 32'(st) | (32'(sel & 1) << 8));
            count_en(16, c);
            for (int k = 0; k < 4; k++) on[k] = (c[k] > 0);
            chk(on, (st == 2'd1) ? 32'he : (st == 2'd2) ? 32'h6 : 32'h0);
            if (st != 2'd3) begin
                ram_chk(32'h0000_2FFF, st == 2'd1);
                ram_chk(32'h0000_0000, st == 2'd1);
                ram_chk(32'h0000_3000, 1'b0);
            end
            pulse(1'b1);
            @(posedge clk);
            #1 chk({core_halt_q, wake_resume_q}, 32'h2);
            pulse(1'b0);
            chk({core_halt_q, wake_resume_q}, 32'h1);
            @(posedge clk);
            #1 chk(wake_resume_q, 32'h0);
            rd_chk(`LPM_OFF_STAT, 32'(sel & 1) << 8);
        end
        ram_chk(32'h0000_2FFF, 1'b1);
        // high then middle mode applied during normal operation as well
        reg_wr(`LPM_OFF_SBY, 32'h0000_0000);
        @(posedge clk);
        #1 chk(power_mode_q, 32'h0);
        reg_wr(`LPM_OFF_SBY, 32'h0000_0100);
        @(posedge clk);
        #1 chk(power_mode_q, 32'h1);
        reg_rd(`LPM_OFF_SBY, d);
        chk(d, 32'h0000_0100);
        summarize();
    end

endmodule : lpm_ctrl_tb_top
`default_nettype wire
